// >>> src/lcc_chain_fabric.sv
`timescale 1ns/1ps
`default_nettype none


module lcc_chain_fabric
    import lcc_pkg::*;
#(
    parameter int NCELLS = `LCC_NCELLS,
    parameter int HALF = `LCC_HALF,
    parameter bit COLUMN_PARITY = `LCC_COL_TOP_BYP,
    parameter bit GLOBAL_CLEAR_EN = 1'b1
) (
    input wire logic mclk,                                 // Cluster clock source
    input wire logic resetn,                               // Sync reset, low
    input wire logic global_clear_n,                       // Device-wide clear, low
    input wire logic cluster_clock_enable_1,               // Enable of clock group 1
    input wire logic cluster_clock_enable_2,               // Enable of clock group 2
    input wire logic [`LCC_NCLEAR-1:0] cluster_clear,      // Two cluster clears, high
    input wire logic carry_origin_fifth,                   // Carry enters at fifth cell
    input wire logic share_origin_sixth,                   // Shared chain enters at sixth cell
    input wire logic half_bypass,                          // Skip the column's bypassable half
    input wire lcc_chain_s chain_in,                       // Links from cluster above
    input wire logic reg_chain_in,                         // Cascade from cluster above
    input wire lcc_cell_cfg_s [NCELLS-1:0] cell_cfg,       // Per-cell configuration
    input wire lcc_cell_in_s [NCELLS-1:0] cell_in,         // Per-cell operands
    output var lcc_chain_s chain_out,                      // Links to cluster below
    output logic reg_chain_out,                            // Cascade to cluster below
    output var lcc_cell_out_s [NCELLS-1:0] cell_out,       // Per-cell register outputs
    output logic final_carry                               // Captured chain carry-out
);

    // Elaboration checks
    if (HALF < 2 || NCELLS != 2 * HALF) begin : g_bad_size
        $error("lcc_chain_fabric: NCELLS must be twice HALF, HALF at least 2");
    end
    if (`LCC_CARRY_ORG_ALT >= HALF || `LCC_SHARE_ORG_ALT != HALF) begin : g_bad_org
        $error("lcc_chain_fabric: chain origins do not fit the half size");
    end

    logic glob_clr;
    logic top_byp;
    logic bot_byp;
    logic [`LCC_NCLK-1:0] clk_en;
    logic [`LCC_NCLK-1:0] gclk;
    logic [`LCC_NCLEAR-1:0] clr_src;
    lcc_chain_s [NCELLS-1:0] link_in;
    lcc_chain_s [NCELLS-1:0] link_out;
    logic [NCELLS-1:0] rchain_in;
    logic [NCELLS-1:0] rchain_out;
    lcc_cell_cfg_s [NCELLS-1:0] cfg_eff;
    logic final_carry_reg;
    logic final_carry_next;

    // Global clear is honoured only when the option is built in
    assign glob_clr = GLOBAL_CLEAR_EN & ~global_clear_n;

    // Each clock group keeps its own enable; never crossed
    assign clk_en = {cluster_clock_enable_2, cluster_clock_enable_1};

    // Clock gates: enable latched in the low phase, so no runt pulses.
    // Reset forces the gate open so the sync reset reaches every register.
    for (genvar g = 0; g < `LCC_NCLK; g++) begin : g_gate
        logic en_lat;
        always_latch begin
            if (!mclk) begin
                en_lat <= clk_en[g] | ~resetn;
            end
        end
        assign gclk[g] = mclk & en_lat;
    end

    // Only two clear sources exist; global clear joins both
    assign clr_src = cluster_clear | {`LCC_NCLEAR{glob_clr}};

    // Which half may be skipped depends on the column parity
    assign top_byp = half_bypass & (COLUMN_PARITY == `LCC_COL_TOP_BYP);
    assign bot_byp = half_bypass & (COLUMN_PARITY == `LCC_COL_BOT_BYP);

    // Cells in a skipped half have their adders parked, freeing them
    always_comb begin
        cfg_eff = cell_cfg;
        for (int i = 0; i < NCELLS; i++) begin
            if ((top_byp && i < HALF) || (bot_byp && i >= HALF)) begin
                if (cell_cfg[i].mode == LCC_MODE_ARITH || cell_cfg[i].mode == LCC_MODE_SHARED) begin
                    cfg_eff[i].mode = LCC_MODE_OFF;
                end
            end
        end
    end

    // Carry routing between cells and across cluster boundaries
    always_comb begin
        for (int i = 0; i < NCELLS; i++) begin
            if (i == 0) begin
                // Top entry; dead when the top half is skipped
                link_in[i].carry = top_byp ? 1'b0 : chain_in.carry;
            end else if (i == `LCC_CARRY_ORG_ALT && carry_origin_fifth && !top_byp) begin
                link_in[i].carry = chain_in.carry;
            end else if (i == HALF && top_byp) begin
                // Bottom-half chain enters the bottom half directly
                link_in[i].carry = chain_in.carry;
            end else if (i >= HALF && bot_byp) begin
                link_in[i].carry = 1'b0;
            end else begin
                link_in[i].carry = link_out[i-1].carry;
            end
        end
        // Shared chain routing, mirroring the carry routing; kept in the
        // same process so the link array has a single driver
        for (int i = 0; i < NCELLS; i++) begin
            if (i == 0) begin
                link_in[i].share = top_byp ? 1'b0 : chain_in.share;
            end else if (i == `LCC_SHARE_ORG_ALT && (share_origin_sixth || top_byp)) begin
                link_in[i].share = chain_in.share;
            end else if (i >= HALF && bot_byp) begin
                link_in[i].share = 1'b0;
            end else begin
                link_in[i].share = link_out[i-1].share;
            end
        end
    end

    // Chain exits: a top-only chain leaves after the last top cell
    always_comb begin
        if (bot_byp) begin
            chain_out = link_out[HALF-1];
        end else begin
            chain_out = link_out[NCELLS-1];
        end
    end

    // Register cascade runs straight through all cells
    always_comb begin
        rchain_in[0] = reg_chain_in;
        for (int i = 1; i < NCELLS; i++) begin
            rchain_in[i] = rchain_out[i-1];
        end
    end
    assign reg_chain_out = rchain_out[NCELLS-1];

    // The cells, each on its chosen clock group and clear
    for (genvar i = 0; i < NCELLS; i++) begin : g_cell
        lcc_logic_cell u_cell (
            .gclk(gclk[cell_cfg[i].clk_sel]),
            .clr(clr_src[cell_cfg[i].clr_sel]),
            .resetn(resetn),
            .cfg(cfg_eff[i]),
            .din(cell_in[i]),
            .chain_in(link_in[i]),
            .reg_chain_in(rchain_in[i]),
            .chain_out(link_out[i]),
            .reg_chain_out(rchain_out[i]),
            .dout(cell_out[i])
        );
    end

    // Final carry lands in a register so routing sees a clean level
    always_comb begin
        if (!resetn) begin
            final_carry_next = `LCC_REG_RST;
        end else begin
            final_carry_next = chain_out.carry;
        end
    end

    // Ungated: the captured carry must track even with groups stopped
    always_ff @(posedge mclk or posedge glob_clr) begin
        if (glob_clr) begin
            final_carry_reg <= `LCC_REG_RST;
        end else begin
            final_carry_reg <= final_carry_next;
        end
    end

    assign final_carry = final_carry_reg;

endmodule

`default_nettype wire

// >>> src/lcc_map.svh
`ifndef LCC_MAP_SVH
`define LCC_MAP_SVH

// Cells in one cluster and cells in one half
`define LCC_NCELLS 10
`define LCC_HALF 5

// Alternate chain origins, as cell indices
`define LCC_CARRY_ORG_ALT 4
`define LCC_SHARE_ORG_ALT 5

// Adder bits per cell and clock/clear groups per cluster
`define LCC_CELL_BITS 2
`define LCC_NCLK 2
`define LCC_NCLEAR 2

// Column parity codes for half bypass
`define LCC_COL_TOP_BYP 1'b0
`define LCC_COL_BOT_BYP 1'b1

// Reset values
`define LCC_REG_RST 1'b0
`define LCC_EN_RST 1'b1

`endif

// >>> src/lcc_pkg.sv
`include "lcc_map.svh"

package lcc_pkg;

    // Cell operating mode, one-hot
    typedef enum logic [3:0] {
        LCC_MODE_OFF    = 4'h1,
        LCC_MODE_ARITH  = 4'h2,
        LCC_MODE_SHARED = 4'h4,
        LCC_MODE_LATREG = 4'h8
    } lcc_mode_e;

    // Per-cell configuration
    typedef struct packed {
        lcc_mode_e mode;
        logic reg_chain;
        logic invert;
        logic clk_sel;
        logic clr_sel;
    } lcc_cell_cfg_s;

    // Per-cell operands from local routing
    typedef struct packed {
        logic [`LCC_CELL_BITS-1:0] x;
        logic [`LCC_CELL_BITS-1:0] y;
        logic [`LCC_CELL_BITS-1:0] z;
    } lcc_cell_in_s;

    // Per-cell registered outputs
    typedef struct packed {
        logic q2;
        logic [`LCC_CELL_BITS-1:0] q;
    } lcc_cell_out_s;

    // Dedicated cell-to-cell arithmetic links
    typedef struct packed {
        logic carry;
        logic share;
    } lcc_chain_s;

endpackage

// >>> src/lcc_logic_cell.sv
`timescale 1ns/1ps
`default_nettype none

module lcc_logic_cell
    import lcc_pkg::*;
(
    input wire logic gclk,                // Gated cluster clock
    input wire logic clr,                 // Async clear, high
    input wire logic resetn,              // Sync reset, low
    input wire lcc_cell_cfg_s cfg,        // Cell configuration
    input wire lcc_cell_in_s din,         // Operands
    input wire lcc_chain_s chain_in,      // Carry and shared links in
    input wire logic reg_chain_in,        // Register cascade in
    output var lcc_chain_s chain_out,     // Carry and shared links out
    output logic reg_chain_out,           // Register cascade out
    output var lcc_cell_out_s dout        // Registered outputs
);

    logic [1:0] lut_sum;
    logic [1:0] lut_car;
    logic [1:0] add_a;
    logic [1:0] add_b;
    logic [1:0] sum;
    logic [1:0] gen;
    logic [1:0] prop;
    logic add_cin;
    logic c0;
    logic co_if0;
    logic co_if1;
    logic lat_d;
    logic mst_lat;
    logic slv_lat;
    logic [1:0] q_reg;
    logic [1:0] q_next;

    // Four tables: two sum bits and two carry bits of x+y+z
    always_comb begin
        lut_sum = din.x ^ din.y ^ din.z;
        lut_car = (din.x & din.y) | (din.x & din.z) | (din.y & din.z);
        add_a = 2'h0;
        add_b = 2'h0;
        add_cin = 1'b0;
        case (cfg.mode)
            LCC_MODE_ARITH: begin
                add_a = din.x;
                add_b = din.y;
                add_cin = chain_in.carry;
            end
            LCC_MODE_SHARED: begin
                add_a = lut_sum;
                add_b = {lut_car[0], chain_in.share};
                add_cin = chain_in.carry;
            end
            default: begin
                // Idle adders see all zeros to stop toggling
                add_a = 2'h0;
            end
        endcase
    end

    // First adder takes the incoming carry, second takes its carry
    assign c0 = (add_a[0] & add_b[0]) | (add_cin & (add_a[0] ^ add_b[0]));
    assign sum = {add_a[1] ^ add_b[1] ^ c0, add_a[0] ^ add_b[0] ^ add_cin};

    // Both carry-outs precomputed; the late carry only drives one mux
    assign gen = add_a & add_b;
    assign prop = add_a ^ add_b;
    assign co_if0 = gen[1] | (prop[1] & gen[0]);
    assign co_if1 = gen[1] | (prop[1] & (gen[0] | prop[0]));
    assign chain_out.carry = add_cin ? co_if1 : co_if0;
    assign chain_out.share = (cfg.mode == LCC_MODE_SHARED) ? lut_car[1] : 1'b0;

    // Two dedicated registers: adder result or cascade shift
    always_comb begin
        if (!resetn) begin
            q_next = {2{`LCC_REG_RST}};
        end else if (cfg.reg_chain) begin
            q_next = {q_reg[0], reg_chain_in};
        end else begin
            q_next = sum ^ {2{cfg.invert}};
        end
    end

    always_ff @(posedge gclk or posedge clr) begin
        if (clr) begin
            q_reg <= {2{`LCC_REG_RST}};
        end else begin
            q_reg <= q_next;
        end
    end

    // Third register from two table latches, same clock and clear as top
    assign lat_d = (cfg.mode == LCC_MODE_LATREG) & resetn & (din.x[0] ^ cfg.invert);

    always_latch begin
        if (clr) begin
            mst_lat <= `LCC_REG_RST;
        end else if (!gclk) begin
            mst_lat <= lat_d;
        end
    end

    always_latch begin
        if (clr) begin
            slv_lat <= `LCC_REG_RST;
        end else if (gclk) begin
            slv_lat <= mst_lat;
        end
    end

    // Inversion undoes the stored sense, so a clear reads as preset
    assign dout.q = q_reg ^ {2{cfg.invert}};
    assign dout.q2 = slv_lat ^ cfg.invert;
    assign reg_chain_out = q_reg[1];

endmodule

`default_nettype wire

// >>> tb/lcc_nbr_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcc_nbr_model
    import lcc_pkg::*;
(
    input wire logic mclk,            // Column clock
    input wire logic up_carry,        // Carry of cluster above
    input wire logic up_share,        // Share link of cluster above
    input wire logic up_bit,          // Cascade bit of cluster above
    input wire lcc_chain_s chain_out, // Links leaving the fabric
    output var lcc_chain_s chain_in,  // Links into the fabric
    output logic reg_chain_in,        // Cascade into the fabric
    output logic below_carry          // Carry taken by cluster below
);
    // Cluster above holds its links as plain levels
    assign chain_in = {up_carry, up_share};
    assign reg_chain_in = up_bit;
    // Cluster below captures the arriving carry in its first cell
    always_ff @(posedge mclk) begin
        below_carry <= chain_out.carry;
    end
endmodule
`default_nettype wire

// >>> tb/lcc_chain_fabric_chk.sv
`timescale 1ns/1ps
`default_nettype none
module lcc_chain_fabric_chk
    import lcc_pkg::*;
#(
    parameter int NCELLS = 10,
    parameter int HALF = 5,
    parameter bit COLUMN_PARITY = 1'b0,
    parameter bit GLOBAL_CLEAR_EN = 1'b1
) (
    input wire logic mclk,                           // Clock
    input wire logic resetn,                         // Sync reset, low
    input wire logic global_clear_n,                 // Device clear, low
    input wire logic cluster_clock_enable_1,         // Group 1 enable
    input wire logic cluster_clock_enable_2,         // Group 2 enable
    input wire logic [1:0] cluster_clear,            // Cluster clears
    input wire logic carry_origin_fifth,             // Carry origin select
    input wire logic share_origin_sixth,             // Share origin select
    input wire logic half_bypass,                    // Half bypass
    input wire lcc_chain_s chain_in,                 // Links in
    input wire logic reg_chain_in,                   // Cascade in
    input wire lcc_cell_cfg_s [NCELLS-1:0] cell_cfg, // Cell setup
    input wire lcc_cell_in_s [NCELLS-1:0] cell_in,   // Operands
    input wire lcc_chain_s chain_out,                // Links out
    input wire logic reg_chain_out,                  // Cascade out
    input wire lcc_cell_out_s [NCELLS-1:0] cell_out, // Cell outputs
    input wire logic final_carry                     // Captured carry
);
    default clocking cb @(posedge mclk); endclocking
    // Cell 0 on group 1 with no clear in play
    logic quiet;
    logic g0;
    logic [1:0] sum0;
    assign quiet = global_clear_n && cluster_clear == 2'h0;
    assign g0 = resetn && quiet && !cell_cfg[0].clk_sel;
    assign sum0 = cell_in[0].x + cell_in[0].y + {1'b0, chain_in.carry};
    a_final_carry_follow: assert property (disable iff (!global_clear_n) resetn |=>
        final_carry == $past(chain_out.carry)) else $error("final carry lost");
    a_global_clear_wins: assert property (GLOBAL_CLEAR_EN && !global_clear_n |->
        !final_carry && cell_out[0].q == {2{cell_cfg[0].invert}}) else $error("global clear ignored");
    a_cluster_clear_pick: assert property (cluster_clear[cell_cfg[1].clr_sel] |->
        cell_out[1].q == {2{cell_cfg[1].invert}}) else $error("cluster clear ignored");
    a_cascade_out_tie: assert property (disable iff (!resetn)
        reg_chain_out == (cell_out[NCELLS-1].q[1] ^ cell_cfg[NCELLS-1].invert)) else $error("cascade out mismatch");
    a_gate_hold_cell: assert property (disable iff (!resetn) g0 && !cluster_clock_enable_1 |=>
        $stable(cell_out[0]) || !quiet || $changed(cell_cfg[0].invert)) else $error("gated cell moved");
    a_latch_third_reg: assert property (disable iff (!resetn) g0 && cluster_clock_enable_1 &&
        cell_cfg[0].mode == LCC_MODE_LATREG && !cell_cfg[0].invert |=>
        cell_out[0].q2 == $past(cell_in[0].x[0]) || !quiet || cell_cfg[0].invert) else $error("third reg wrong");
    a_arith_first_cell: assert property (disable iff (!resetn) g0 && cluster_clock_enable_1 &&
        cell_cfg[0].mode == LCC_MODE_ARITH && !half_bypass && !cell_cfg[0].invert |=>
        cell_out[0].q == $past(sum0) || !quiet || cell_cfg[0].invert) else $error("first cell sum wrong");
    a_idle_links_low: assert property (cell_cfg[NCELLS-1].mode == LCC_MODE_OFF &&
        (!COLUMN_PARITY || !half_bypass) |-> chain_out == 2'h0) else $error("idle cell drives links");
endmodule
bind lcc_chain_fabric lcc_chain_fabric_chk #(.NCELLS(NCELLS), .HALF(HALF), .COLUMN_PARITY(COLUMN_PARITY),
    .GLOBAL_CLEAR_EN(GLOBAL_CLEAR_EN)) i_chk (.mclk, .resetn, .global_clear_n, .cluster_clock_enable_1,
    .cluster_clock_enable_2, .cluster_clear, .carry_origin_fifth, .share_origin_sixth, .half_bypass,
    .chain_in, .reg_chain_in, .cell_cfg, .cell_in, .chain_out, .reg_chain_out, .cell_out, .final_carry);
`default_nettype wire

// >>> tb/logic_cluster_chain_fabric_test.sv
`timescale 1ns/1ps
`default_nettype none
module logic_cluster_chain_fabric_test;
    import lcc_pkg::*;
    localparam logic [19:0] OP_A = 20'hABCDE;
    localparam logic [19:0] OP_B = 20'h5432F;
    // Bench-driven inputs and observed outputs
    logic mclk = 1'b0, resetn = 1'b0, gclr_n = 1'b1, en1 = 1'b1, en2 = 1'b1, c5 = 1'b0, s6 = 1'b0, byp = 1'b0;
    logic up_c = 1'b0, up_s = 1'b0, up_b = 1'b0, rc_in, rc_out, fcar, below;
    logic [1:0] clr = 2'h0;
    lcc_chain_s c_in, c_out;
    lcc_cell_cfg_s [9:0] cfg;
    lcc_cell_in_s [9:0] din = '0;
    lcc_cell_out_s [9:0] dout;
    int fail_count = 0;
    int comparisons = 0;
    // 125 MHz clock
    always #4 mclk = ~mclk;
    lcc_chain_fabric i_dut (.mclk, .resetn, .global_clear_n(gclr_n), .cluster_clock_enable_1(en1),
        .cluster_clock_enable_2(en2), .cluster_clear(clr), .carry_origin_fifth(c5), .share_origin_sixth(s6),
        .half_bypass(byp), .chain_in(c_in), .reg_chain_in(rc_in), .cell_cfg(cfg), .cell_in(din),
        .chain_out(c_out), .reg_chain_out(rc_out), .cell_out(dout), .final_carry(fcar));
    lcc_nbr_model i_nbr (.mclk, .up_carry(up_c), .up_share(up_s), .up_bit(up_b), .chain_out(c_out),
        .chain_in(c_in), .reg_chain_in(rc_in), .below_carry(below));
    // Compare and close
    task automatic chk_v(input string n, input logic [19:0] e, input logic [19:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_b(input string n, input logic e, input logic g);
        chk_v(n, {19'h0, e}, {19'h0, g});
    endtask
    task automatic conclude();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Inputs always move 1 ns after the edge, clear of sampling
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    function automatic logic [19:0] qbits(input logic third);
        qbits = '0;
        for (int i = 0; i < 10; i++) begin
            if (third)
                qbits[i] = dout[i].q2;
            else
                qbits[2*i+:2] = dout[i].q;
        end
    endfunction
    function automatic logic maj(input logic a, input logic b, input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction
    // Group and clear alternate by cell, so both pairs get used
    task automatic cfg_all(input lcc_mode_e m, input logic rc, input logic inv);
        for (int i = 0; i < 10; i++) cfg[i] = '{m, rc, inv, i[0], i[0]};
    endtask
    task automatic put(input logic [19:0] a, input logic [19:0] b, input logic [19:0] z);
        for (int i = 0; i < 10; i++) din[i] = {a[2*i+:2], b[2*i+:2], z[2*i+:2]};
    endtask
    // Links are checked before the edge, registers after it
    task automatic run_add(input logic [19:0] e, input logic co);
        put(OP_A, OP_B, 20'h0);
        #2;
        chk_b("chain_carry", co, c_out.carry);
        tick(1);
        chk_v("sum", e, qbits(1'b0));
        chk_b("final_carry", co, fcar);
        chk_b("below_carry", co, below);
    endtask
    task automatic t_arith();
        logic [20:0] s;
        cfg_all(LCC_MODE_ARITH, 1'b0, 1'b0);
        up_c = 1'b1;
        s = OP_A + OP_B + 21'h1;
        run_add(s[19:0], s[20]);
    endtask
    // Fifth-cell origin splits the chain; bypass drops the top half
    task automatic t_split(input logic bp);
        logic [12:0] hi;
        logic [8:0] lo;
        c5 = !bp;
        byp = bp;
        if (bp) begin
            hi = OP_A[19:10] + OP_B[19:10] + 13'h1;
            run_add({hi[9:0], 10'h0}, hi[10]);
        end else begin
            lo = OP_A[7:0] + OP_B[7:0] + 9'h1;
            hi = OP_A[19:8] + OP_B[19:8] + 13'h1;
            run_add({hi[11:0], lo[7:0]}, hi[12]);
        end
    endtask
    // Sixth-cell origin or top bypass restarts the shared chain at cell five
    task automatic t_shared(input logic o6, input logic bp);
        logic [19:0] x = 20'h9B4E7, y = 20'h3C6A5, z = 20'hE1D38, e;
        logic [1:0] av, bv;
        logic [2:0] t;
        logic c = 1'b1, sh = 1'b1;
        cfg_all(LCC_MODE_SHARED, 1'b0, 1'b0);
        up_s = 1'b1;
        s6 = o6;
        byp = bp;
        for (int i = 0; i < 10; i++) begin
            if (i == 5 && (o6 || bp))
                sh = up_s;
            if (i == 5 && bp)
                c = up_c;
            av = x[2*i+:2] ^ y[2*i+:2] ^ z[2*i+:2];
            bv = {maj(x[2*i], y[2*i], z[2*i]), sh};
            t = av + bv + c;
            if (bp && i < 5)
                t = 3'h0;
            e[2*i+:2] = t[1:0];
            c = t[2];
            sh = maj(x[2*i+1], y[2*i+1], z[2*i+1]);
        end
        put(x, y, z);
        #2;
        chk_b("share_link", sh, c_out.share);
        chk_b("shared_carry", c, c_out.carry);
        tick(1);
        chk_v("shared_sum", e, qbits(1'b0));
    endtask
    task automatic t_latreg();
        cfg_all(LCC_MODE_LATREG, 1'b0, 1'b0);
        put(20'h55555, 20'h0, 20'h0);
        tick(1);
        chk_v("third_reg", 20'h003FF, qbits(1'b1));
        en1 = 1'b0;
        put(20'h0, 20'h0, 20'h0);
        tick(1);
        chk_v("third_hold", 20'h00155, qbits(1'b1));
        en1 = 1'b1;
        tick(1);
        chk_v("third_reg", 20'h0, qbits(1'b1));
    endtask
    // Shift a pattern through all twenty registers, then freeze
    task automatic t_cascade();
        logic [19:0] pat = 20'hC3A51;
        cfg_all(LCC_MODE_OFF, 1'b1, 1'b0);
        for (int k = 0; k < 20; k++) begin
            up_b = pat[k];
            tick(1);
        end
        chk_v("cascade", 20'h8A5C3, qbits(1'b0));
        chk_b("cascade_out", pat[0], rc_out);
        en1 = 1'b0;
        en2 = 1'b0;
        up_b = 1'b0;
        tick(3);
        chk_v("cascade_hold", 20'h8A5C3, qbits(1'b0));
    endtask
    // Second clear hits odd cells only; device clear with invert presets.
    // Both clears straddle an edge so the checker samples them too.
    task automatic t_clear();
        clr = 2'h2;
        #2;
        chk_v("clear_odd", 20'h02103, qbits(1'b0));
        tick(1);
        chk_v("clear_hold", 20'h02103, qbits(1'b0));
        clr = 2'h0;
        en1 = 1'b1;
        en2 = 1'b1;
        cfg_all(LCC_MODE_OFF, 1'b0, 1'b1);
        gclr_n = 1'b0;
        #2;
        chk_v("preset", 20'hFFFFF, qbits(1'b0));
        chk_b("final_clear", 1'b0, fcar);
        tick(1);
        chk_v("preset_hold", 20'hFFFFF, qbits(1'b0));
        gclr_n = 1'b1;
        tick(1);
    endtask
    initial begin
        cfg_all(LCC_MODE_OFF, 1'b0, 1'b0);
        tick(12);
        resetn = 1'b1;
        t_arith();
        t_split(1'b0);
        t_split(1'b1);
        t_shared(1'b0, 1'b0);
        t_shared(1'b1, 1'b0);
        t_shared(1'b0, 1'b1);
        up_s = 1'b0;
        s6 = 1'b0;
        byp = 1'b0;
        t_latreg();
        t_cascade();
        t_clear();
        conclude();
    end
    // Whole run needs about 47 cycles; allow far more
    initial begin
        #8000;
        fail_count++;
        conclude();
    end
endmodule
`default_nettype wire
